// ### design/ccr_regs.sv
/*
 * ccr_regs: converter control register bank with bias, channel reset, sinc gain and two aux clock dividers.
 * assumes synchronous inputs on clk, one-cycle strobes, read data valid the cycle after the read strobe.
 */
// Decided for this implementation: the strobed register port.
// Overview of operation
// - bits 1:0 of the bias register set dac channel 1 bias: 00 default, 01 at 125 percent, 10 or 11 at 75 percent.
// - bits 3:2 of the bias register set dac channel 2 bias with the same coding.
// - reset register bits 0 to 3 hold adc channels 1 to 4 in reset while one.
// - reset register bits 4 to 7 hold dac channels 1 to 4 in reset while one.
// - the gain register gives each adc channel two bits: 00 0 dB, 01 +30 dB, 10 +60 dB, 11 0 dB.
// - aux clock a runs at 6.144 MHz over the divider value plus one, divider resetting to 00000101.
// - aux clock b runs at 512 kHz over the divider value plus one, divider resetting to zero.
`timescale 1ns/100ps
module ccr_regs
	import ccr_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire ccr_req_t   req,
	output logic [7:0]      rdata,
	output ccr_ctl_t        ctl,
	output logic            aux_clock_out_a,
	output logic            aux_clock_out_b
);

	logic [7:0] bias_reg, reset_reg, gain_reg, diva_reg, divb_reg;
	logic [7:0] cnta_reg, cntb_reg;
	logic [7:0] ticka_reg, tickb_reg;
	logic       ena, enb;

	// register writes; reset bits never clear on their own
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bias_reg  <= CCR_RST_BIAS;
			reset_reg <= CCR_RST_RESET;
			gain_reg  <= CCR_RST_GAIN;
			diva_reg  <= CCR_RST_DIVA;
			divb_reg  <= CCR_RST_DIVB;
		end else if (req.wr) begin
			unique case (req.addr)
				CCR_OFF_BIAS:  bias_reg  <= req.wdata;
				CCR_OFF_RESET: reset_reg <= req.wdata;
				CCR_OFF_GAIN:  gain_reg  <= req.wdata;
				CCR_OFF_DIVA:  diva_reg  <= req.wdata;
				CCR_OFF_DIVB:  divb_reg  <= req.wdata;
				default: ; // unmapped writes are dropped
			endcase
		end
	end

	// read data one cycle after the strobe, zero when idle or unmapped
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata <= 8'h00;
		end else if (req.rd) begin
			unique case (req.addr)
				CCR_OFF_BIAS:  rdata <= bias_reg;
				CCR_OFF_RESET: rdata <= reset_reg;
				CCR_OFF_GAIN:  rdata <= gain_reg;
				CCR_OFF_DIVA:  rdata <= diva_reg;
				CCR_OFF_DIVB:  rdata <= divb_reg;
				CCR_OFF_STAT:  rdata <= {6'h00, aux_clock_out_b, aux_clock_out_a};
				default:       rdata <= 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end

	// decode of the analog controls, registered so outputs come from flops
	function automatic ccr_bias_t bias_dec(input logic [1:0] c);
		if (c == CCR_BIAS_CODE_DEF)
			return CCR_BIAS_DEFAULT;
		else if (c == CCR_BIAS_CODE_HI)
			return CCR_BIAS_125;
		else
			return CCR_BIAS_75; // 10 and 11 both give the low level
	endfunction

	function automatic ccr_gain_t gain_dec(input logic [1:0] c);
		if (c == CCR_GAIN_CODE_30)
			return CCR_GAIN_30DB;
		else if (c == CCR_GAIN_CODE_60)
			return CCR_GAIN_60DB;
		else
			return CCR_GAIN_0DB; // 11 folds back to 0 dB
	endfunction

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctl <= '0;
		end else begin
			ctl.dac_bias[0] <= bias_dec(bias_reg[CCR_BIAS1_LSB +: 2]);
			ctl.dac_bias[1] <= bias_dec(bias_reg[CCR_BIAS2_LSB +: 2]);
			ctl.adc_reset   <= reset_reg[CCR_ADCRST_LSB +: 4];
			ctl.dac_reset   <= reset_reg[CCR_DACRST_LSB +: 4];
			for (int i = 0; i < 4; i++) begin
				ctl.sinc_gain[i] <= gain_dec(gain_reg[2*i +: 2]);
			end
		end
	end

	// half-period enables of each base rate; both stay below 256 clocks so eight-bit counters suffice
	// a dedicated reference clock would remove the rate error that the integer division leaves
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ticka_reg <= 8'h00;
			tickb_reg <= 8'h00;
		end else begin
			ticka_reg <= ena ? 8'h00 : ticka_reg + 8'h01;
			tickb_reg <= enb ? 8'h00 : tickb_reg + 8'h01;
		end
	end
	assign ena = (ticka_reg == 8'(CCR_HALFA_CYC - 1));
	assign enb = (tickb_reg == 8'(CCR_HALFB_CYC - 1));

	// output toggles every divider+1 half base periods: base rate over divider+1 at 50 percent duty
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnta_reg        <= 8'h00;
			aux_clock_out_a <= 1'b0;
		end else if (ena) begin
			if (cnta_reg >= diva_reg) begin
				cnta_reg        <= 8'h00;
				aux_clock_out_a <= ~aux_clock_out_a;
			end else begin
				cnta_reg <= cnta_reg + 8'h01;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cntb_reg        <= 8'h00;
			aux_clock_out_b <= 1'b0;
		end else if (enb) begin
			if (cntb_reg >= divb_reg) begin
				cntb_reg        <= 8'h00;
				aux_clock_out_b <= ~aux_clock_out_b;
			end else begin
				cntb_reg <= cntb_reg + 8'h01;
			end
		end
	end

	// assertions
	reset_hold_a: assert property (@(posedge clk) disable iff (rst)
		!(req.wr && req.addr == CCR_OFF_RESET) |=> reset_reg == $past(reset_reg))
		else $error("reset bits changed without a write");
	adc_reset_a: assert property (@(posedge clk) disable iff (rst)
		ctl.adc_reset == $past(reset_reg[3:0]))
		else $error("adc reset output does not follow register");
	dac_reset_a: assert property (@(posedge clk) disable iff (rst)
		ctl.dac_reset == $past(reset_reg[7:4]))
		else $error("dac reset output does not follow register");
	bias_one_a: assert property (@(posedge clk) disable iff (rst)
		bias_reg[1] |=> ctl.dac_bias[0] == CCR_BIAS_75)
		else $error("dac1 bias high codes not 75 percent");
	bias_two_a: assert property (@(posedge clk) disable iff (rst)
		bias_reg[3:2] == 2'h1 ##1 bias_reg[3:2] == 2'h1 |-> ctl.dac_bias[1] == CCR_BIAS_125)
		else $error("dac2 bias code 01 not 125 percent");
	gain_fold_a: assert property (@(posedge clk) disable iff (rst)
		gain_reg[7:6] == 2'h3 ##1 gain_reg[7:6] == 2'h3 |-> ctl.sinc_gain[3] == CCR_GAIN_0DB)
		else $error("gain code 11 not 0 dB");
	clka_rate_a: assert property (@(posedge clk) disable iff (rst)
		$changed(aux_clock_out_a) |-> $past(ena) && ($past(cnta_reg) >= $past(diva_reg)))
		else $error("aux clock a toggled off its count");
	clkb_rate_a: assert property (@(posedge clk) disable iff (rst)
		enb && divb_reg == 8'h00 && cntb_reg == 8'h00 |=> $changed(aux_clock_out_b))
		else $error("aux clock b with zero divider missed a toggle");
	read_zero_a: assert property (@(posedge clk) disable iff (rst)
		!req.rd |=> rdata == 8'h00)
		else $error("read data not zero outside read cycle");

	// read-back: the byte returned one cycle after the strobe is the register as it stood at the strobe
	read_bias_a: assert property (@(posedge clk) disable iff (rst)
		req.rd && req.addr == CCR_OFF_BIAS |=> rdata == $past(bias_reg))
		else $error("bias register read back wrong");
	read_chan_a: assert property (@(posedge clk) disable iff (rst)
		req.rd && req.addr == CCR_OFF_RESET |=> rdata == $past(reset_reg))
		else $error("channel reset register read back wrong");
	read_gain_a: assert property (@(posedge clk) disable iff (rst)
		req.rd && req.addr == CCR_OFF_GAIN |=> rdata == $past(gain_reg))
		else $error("gain register read back wrong");
	read_diva_a: assert property (@(posedge clk) disable iff (rst)
		req.rd && req.addr == CCR_OFF_DIVA |=> rdata == $past(diva_reg))
		else $error("divider a read back wrong");
	read_divb_a: assert property (@(posedge clk) disable iff (rst)
		req.rd && req.addr == CCR_OFF_DIVB |=> rdata == $past(divb_reg))
		else $error("divider b read back wrong");
	read_stat_a: assert property (@(posedge clk) disable iff (rst)
		req.rd && req.addr == CCR_OFF_STAT |=> rdata == {6'h00, $past(aux_clock_out_b), $past(aux_clock_out_a)})
		else $error("status read back wrong");

	// writes land in one cycle; a divider only moves when software writes it
	write_bias_a: assert property (@(posedge clk) disable iff (rst)
		req.wr && req.addr == CCR_OFF_BIAS |=> bias_reg == $past(req.wdata))
		else $error("bias write did not land");
	diva_hold_a: assert property (@(posedge clk) disable iff (rst)
		!(req.wr && req.addr == CCR_OFF_DIVA) |=> diva_reg == $past(diva_reg))
		else $error("divider a changed without a write");

	// remaining decode codes, one cycle behind the register
	bias_mid_a: assert property (@(posedge clk) disable iff (rst)
		bias_reg[1:0] == 2'h1 |=> ctl.dac_bias[0] == CCR_BIAS_125)
		else $error("dac1 bias code 01 not 125 percent");
	bias_def_a: assert property (@(posedge clk) disable iff (rst)
		bias_reg[3:2] == 2'h0 |=> ctl.dac_bias[1] == CCR_BIAS_DEFAULT)
		else $error("dac2 bias code 00 not default");
	gain_thirty_a: assert property (@(posedge clk) disable iff (rst)
		gain_reg[1:0] == 2'h1 |=> ctl.sinc_gain[0] == CCR_GAIN_30DB)
		else $error("gain code 01 not +30 dB");
	gain_sixty_a: assert property (@(posedge clk) disable iff (rst)
		gain_reg[3:2] == 2'h2 |=> ctl.sinc_gain[1] == CCR_GAIN_60DB)
		else $error("gain code 10 not +60 dB");
	gain_zero_a: assert property (@(posedge clk) disable iff (rst)
		gain_reg[5:4] == 2'h0 |=> ctl.sinc_gain[2] == CCR_GAIN_0DB)
		else $error("gain code 00 not 0 dB");

	reset_set_c: cover property (@(posedge clk) disable iff (rst) ctl.adc_reset == 4'hf);
	clka_tog_c:  cover property (@(posedge clk) disable iff (rst) $rose(aux_clock_out_a));
	clkb_tog_c:  cover property (@(posedge clk) disable iff (rst) $rose(aux_clock_out_b));
	gain60_c:    cover property (@(posedge clk) disable iff (rst) ctl.sinc_gain[0] == CCR_GAIN_60DB);
	bias125_c:   cover property (@(posedge clk) disable iff (rst) ctl.dac_bias[1] == CCR_BIAS_125);

endmodule

// ### design/ccr_pkg.sv
/*
 * ccr_pkg: offsets, field positions, reset values, codes and timing for the converter control register bank.
 * assumes a single 200 MHz system clock and a plain byte-wide register port.
 */
package ccr_pkg;

	// register offsets
	localparam logic [7:0] CCR_OFF_BIAS  = 8'h1d;
	localparam logic [7:0] CCR_OFF_RESET = 8'h1e;
	localparam logic [7:0] CCR_OFF_GAIN  = 8'h1f;
	localparam logic [7:0] CCR_OFF_DIVA  = 8'h21;
	localparam logic [7:0] CCR_OFF_DIVB  = 8'h22;
	localparam logic [7:0] CCR_OFF_STAT  = 8'h23; // read-only divider state

	// reset values
	localparam logic [7:0] CCR_RST_BIAS  = 8'h00;
	localparam logic [7:0] CCR_RST_RESET = 8'h00;
	localparam logic [7:0] CCR_RST_GAIN  = 8'h00;
	localparam logic [7:0] CCR_RST_DIVA  = 8'h05;
	localparam logic [7:0] CCR_RST_DIVB  = 8'h00;

	// field positions
	localparam int CCR_BIAS1_LSB = 0;
	localparam int CCR_BIAS2_LSB = 2;
	localparam int CCR_ADCRST_LSB = 0;
	localparam int CCR_DACRST_LSB = 4;

	// bias codes, decoded level
	localparam logic [1:0] CCR_BIAS_CODE_DEF = 2'h0;
	localparam logic [1:0] CCR_BIAS_CODE_HI  = 2'h1;
	typedef enum logic [1:0] {
		CCR_BIAS_DEFAULT = 2'h0,
		CCR_BIAS_125     = 2'h1,
		CCR_BIAS_75      = 2'h2
	} ccr_bias_t;

	// sinc gain codes, decoded gain
	localparam logic [1:0] CCR_GAIN_CODE_30 = 2'h1;
	localparam logic [1:0] CCR_GAIN_CODE_60 = 2'h2;
	typedef enum logic [1:0] {
		CCR_GAIN_0DB  = 2'h0,
		CCR_GAIN_30DB = 2'h1,
		CCR_GAIN_60DB = 2'h2
	} ccr_gain_t;

	// timing: base reference rates, derived as enables from the system clock
	localparam int CCR_CLK_KHZ    = 200000;
	localparam int CCR_BASEA_KHZ  = 6144;
	localparam int CCR_BASEB_KHZ  = 512;
	// tick period in clocks; rate error is inherent since 200 MHz is not a multiple
	localparam int CCR_TICKA_CYC  = CCR_CLK_KHZ / CCR_BASEA_KHZ;
	localparam int CCR_TICKB_CYC  = CCR_CLK_KHZ / CCR_BASEB_KHZ;
	// half base periods pace the output toggles, so one output period is divider+1 base periods
	localparam int CCR_HALFA_CYC  = CCR_TICKA_CYC / 2;
	localparam int CCR_HALFB_CYC  = CCR_TICKB_CYC / 2;

	// bus request carrier
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} ccr_req_t;

	// analog control carrier
	typedef struct packed {
		ccr_bias_t [1:0] dac_bias;
		logic [3:0]      adc_reset;
		logic [3:0]      dac_reset;
		ccr_gain_t [3:0] sinc_gain;
	} ccr_ctl_t;

endpackage

// ### test/tb_top.sv
/*
 * tb_top: self-checking bench for the converter control register bank.
 * assumes ccr_pkg and ccr_regs are compiled first and a single 200 MHz clock.
 */
`timescale 1ns/100ps
module tb_top;
	import ccr_pkg::*;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	ccr_req_t   req = '0;
	logic [7:0] rdata;
	ccr_ctl_t   ctl;
	logic       aux_a;
	logic       aux_b;
	int         bad_count = 0;
	int         compares = 0;
	logic [19:0] p;

	ccr_regs DUT (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .ctl(ctl),
		.aux_clock_out_a(aux_a), .aux_clock_out_b(aux_b));

	// free-running system clock
	always #2.5 clk = ~clk;

	task automatic end_of_test();
		if (bad_count == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [19:0] seen, input logic [19:0] exp, input string n);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", n, exp, seen);
		end
	endtask

	// one-cycle strobes driven right after the edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		req.wr <= 1'b1;
		req.addr <= a;
		req.wdata <= d;
		@(posedge clk);
		req.wr <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe, so sample just past that edge
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
		@(posedge clk);
		req.rd <= 1'b1;
		req.addr <= a;
		@(posedge clk);
		req.rd <= 1'b0;
		#1;
		chk(rdata, e, n);
	endtask

	// decoded outputs trail the register by one more edge
	task automatic settle();
		repeat (2) @(posedge clk);
		#1;
	endtask

	function automatic ccr_bias_t bdec(input logic [1:0] c);
		return (c == CCR_BIAS_CODE_DEF) ? CCR_BIAS_DEFAULT : (c == CCR_BIAS_CODE_HI) ? CCR_BIAS_125 : CCR_BIAS_75;
	endfunction

	function automatic ccr_gain_t gdec(input logic [1:0] c);
		return (c == CCR_GAIN_CODE_30) ? CCR_GAIN_30DB : (c == CCR_GAIN_CODE_60) ? CCR_GAIN_60DB : CCR_GAIN_0DB;
	endfunction

	// clock cycles between the second and third rising edge of the chosen aux output
	task automatic period(input logic sel, output logic [19:0] q);
		logic prev;
		int   n;
		int   edges;
		prev = 1'b1;
		n = 0;
		edges = 0;
		q = '0;
		for (int i = 0; i < 6000 && edges < 3; i++) begin
			@(posedge clk);
			#1;
			if ((sel ? aux_b : aux_a) === 1'b1 && prev === 1'b0) begin
				edges++;
				q = 20'(n);
				n = 0;
			end
			prev = sel ? aux_b : aux_a;
			n++;
		end
		if (edges < 3) begin
			bad_count++;
			end_of_test();
		end
	endtask

	task automatic t_reset_vals();
		chk(ctl, '0, "ctl_rst");
		rd(CCR_OFF_BIAS, CCR_RST_BIAS, "bias_rst");
		rd(CCR_OFF_RESET, CCR_RST_RESET, "chan_rst");
		rd(CCR_OFF_GAIN, CCR_RST_GAIN, "gain_rst");
		rd(CCR_OFF_DIVA, 8'h05, "diva_rst");
		rd(CCR_OFF_DIVB, 8'h00, "divb_rst");
	endtask

	// aux periods: one base period per divider step, default divider first
	task automatic t_aux();
		period(1'b0, p);
		chk(p, 20'(6 * CCR_TICKA_CYC), "aux_a_div5");
		wr(CCR_OFF_DIVA, 8'h02);
		period(1'b0, p);
		chk(p, 20'(3 * CCR_TICKA_CYC), "aux_a_div2");
		period(1'b1, p);
		chk(p, 20'(1 * CCR_TICKB_CYC), "aux_b_div0");
		wr(CCR_OFF_DIVB, 8'h01);
		period(1'b1, p);
		chk(p, 20'(2 * CCR_TICKB_CYC), "aux_b_div1");
	endtask

	// every code on both channels, the two channels always differing
	task automatic t_bias();
		for (int c = 0; c < 4; c++) begin
			wr(CCR_OFF_BIAS, 8'(c | ((3 - c) << 2)));
			settle();
			chk({6'h00, ctl.dac_bias[0]}, {6'h00, bdec(2'(c))}, "bias1");
			chk({6'h00, ctl.dac_bias[1]}, {6'h00, bdec(2'(3 - c))}, "bias2");
		end
	endtask

	// rotated patterns put each of the four codes on each channel once
	task automatic t_gain();
		logic [7:0] gv [4] = '{8'he4, 8'h39, 8'h4e, 8'h93};
		for (int r = 0; r < 4; r++) begin
			wr(CCR_OFF_GAIN, gv[r]);
			settle();
			for (int k = 0; k < 4; k++)
				chk({6'h00, ctl.sinc_gain[k]}, {6'h00, gdec(gv[r][2*k+:2])}, "gain");
			rd(CCR_OFF_GAIN, gv[r], "gain_reg");
		end
	endtask

	// reset bits must hold through unrelated traffic; an unmapped write must not land
	task automatic t_chan_reset();
		wr(CCR_OFF_RESET, 8'h5a);
		wr(8'h20, 8'hff);
		repeat (20) @(posedge clk);
		#1;
		chk(ctl.adc_reset, 4'ha, "adc_rst");
		chk(ctl.dac_reset, 4'h5, "dac_rst");
		rd(CCR_OFF_RESET, 8'h5a, "rst_reg");
		rd(8'h20, 8'h00, "unmapped");
		wr(CCR_OFF_RESET, 8'ha5);
		settle();
		chk({ctl.dac_reset, ctl.adc_reset}, 8'ha5, "chan_rst2");
	endtask

	// reset for three cycles, then each scenario in turn
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_reset_vals();
		t_aux();
		t_bias();
		t_gain();
		t_chan_reset();
		// a reset in mid-run must bring back every reset value, held channel resets included
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_reset_vals();
		end_of_test();
	end
endmodule
